// ### shared/scif_pkg.sv
// Shared constants and types for the smart card interface core
package scif_pkg;
  // ==========================================================
  // Sizes
  localparam int DATA_W  = 8;
  localparam int RXE_W   = 9;
  localparam int DEPTH   = 8;
  localparam int CNT_W   = 4;
  localparam int TIME_W  = 16;
  localparam int DIV_W   = 8;
  localparam int RTRY_W  = 3;
  localparam int FRAME_W = 10;
  localparam int IRQ_N   = 12;
  // ==========================================================
  // Interrupt line positions
  localparam int IRQ_CARD_IN  = 0;
  localparam int IRQ_CARD_OUT = 1;
  localparam int IRQ_CARD_UP  = 2;
  localparam int IRQ_CARD_DN  = 3;
  localparam int IRQ_TX_ERR   = 4;
  localparam int IRQ_ATR_STO  = 5;
  localparam int IRQ_ATR_DTO  = 6;
  localparam int IRQ_CHAR_TO  = 7;
  localparam int IRQ_BLK_TO   = 8;
  localparam int IRQ_RX_TOUT  = 9;
  localparam int IRQ_TX_LVL   = 10;
  localparam int IRQ_RX_LVL   = 11;
  // Lines that latch until cleared; the rest follow a level
  localparam logic [IRQ_N-1:0] IRQ_STICKY = 12'h1ef;
  // ==========================================================
  // Frame slots, counted in bit times from the start bit
  localparam logic [3:0] FRM_DATA0 = 4'h1;
  localparam logic [3:0] FRM_PAR   = 4'h9;
  localparam logic [3:0] FRM_ERR   = 4'ha;
  localparam logic [3:0] FRM_END   = 4'hb;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    S_NOCARD, S_DEBOUNCE, S_READY, S_PWR, S_CLK, S_RST, S_ATR_WAIT,
    S_ATR_RX, S_SESSION, S_WARM, S_DEACT_RST, S_DEACT_CLK, S_DEACT_PWR
  } scif_sess_t;
  typedef enum logic [1:0] {L_IDLE, L_TX, L_RX} scif_link_t;
  typedef struct packed {
    logic [TIME_W-1:0] baud;
    logic [DIV_W-1:0]  adjust;
    logic [DIV_W-1:0]  clkdiv;
    logic [TIME_W-1:0] stable_time;
    logic [TIME_W-1:0] act_time;
    logic [TIME_W-1:0] atr_start_time;
    logic [TIME_W-1:0] atr_dur_time;
    logic [TIME_W-1:0] deact_time;
    logic [TIME_W-1:0] rx_idle_time_setting;
    logic [TIME_W-1:0] char_guard;
    logic [TIME_W-1:0] block_guard;
    logic [TIME_W-1:0] char_timeout;
    logic [TIME_W-1:0] block_timeout;
    logic [CNT_W-1:0]  tx_tide;
    logic [CNT_W-1:0]  rx_tide;
    logic [RTRY_W-1:0] tx_retry;
    logic              t1_mode;
  } scif_cfg_t;
  typedef struct packed {
    logic pwr;
    logic clk;
    logic rst_n;
    logic io_out;
    logic io_oe_n;
  } scif_card_t;
endpackage

// ### core/scif_fifo.sv
// Circular buffer with read and write pointers, held in flip-flops
`timescale 1ns/1ps
module scif_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic          mclk_i,
  input  wire logic          rstn_i,
  input  wire logic          wr_i,
  input  wire logic [W-1:0]  wdata_i,
  input  wire logic          rd_i,
  input  wire logic          flush_i,
  output logic      [W-1:0]  rdata_o,
  output logic      [CW-1:0] count_o
);
  localparam int AW = $clog2(DEPTH);
  // ==========================================================
  // Pointer wrap relies on a power of two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("scif_fifo: DEPTH must be a power of two");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [CW-1:0]           cnt;
  } scif_fst_t;
  scif_fst_t st;
  scif_fst_t next_st;
  logic      do_wr;
  logic      do_rd;
  // ==========================================================
  // Next state
  always_comb begin
    next_st = st;
    do_wr   = wr_i && (st.cnt != CW'(DEPTH));
    do_rd   = rd_i && (st.cnt != '0);
    if (flush_i) begin
      next_st.wptr = '0;
      next_st.rptr = '0;
      next_st.cnt  = '0;
    end else begin
      if (do_wr) begin
        next_st.mem[st.wptr] = wdata_i;
        next_st.wptr         = st.wptr + 1'b1;
      end
      if (do_rd) begin
        next_st.rptr = st.rptr + 1'b1;
      end
      case ({do_wr, do_rd})
        2'b10:   next_st.cnt = st.cnt + 1'b1;
        2'b01:   next_st.cnt = st.cnt - 1'b1;
        default: next_st.cnt = st.cnt;
      endcase
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign rdata_o = st.mem[st.rptr];
  assign count_o = st.cnt;
endmodule

// ### core/scif_core.sv
// Smart card interface core: buffers, etu timing, session and link
//
// Behaviour
// - Outgoing characters sit in an eight by eight bit circular buffer.
// - Transmit level line is high while outgoing fill is below threshold.
// - A failed T0 character raises the transmit error line, status bit 4.
// - After a transmit error sending stops until the buffer is flushed.
// - Incoming characters sit in an eight by nine bit circular buffer.
// - Entry bit 8 marks a parity error on that character.
// - Receive level line is high while incoming fill exceeds threshold.
// - Unread characters idle past the set time raise receive timeout.
// - Card clock is toggled by a divide counter on the reference clock.
// - One session counter, reloaded per stage, times all nine timed stages.
// - One spacing counter times guard times and gaps between characters.
// - Power, clock and reset are sequenced on activation; reset, clock, data and power on release.
// - Twelve direct interrupt lines and one OR of them all.
`timescale 1ns/1ps
module scif_core (
  input  wire logic                         mclk_i,
  input  wire logic                         rstn_i,
  input  wire scif_pkg::scif_cfg_t          cfg_i,
  input  wire logic                         card_detect_i,
  input  wire logic                         start_act_i,
  input  wire logic                         deact_req_i,
  input  wire logic                         warm_rst_i,
  input  wire logic                         atr_done_i,
  input  wire logic                         tx_mode_i,
  input  wire logic                         tx_wr_i,
  input  wire logic [scif_pkg::DATA_W-1:0]  tx_wdata_i,
  input  wire logic                         tx_flush_i,
  input  wire logic                         rx_rd_i,
  input  wire logic [scif_pkg::IRQ_N-1:0]   irq_clear_i,
  input  wire logic                         card_io_i,
  output logic                              card_pwr_o,
  output logic                              card_clock_out_o,
  output logic                              card_rst_n_o,
  output logic                              card_io_o,
  output logic                              card_io_oe_n_o,
  output logic      [scif_pkg::RXE_W-1:0]   rx_rdata_o,
  output logic                              rx_rvalid_o,
  output logic      [scif_pkg::CNT_W-1:0]   tx_count_o,
  output logic      [scif_pkg::CNT_W-1:0]   rx_count_o,
  output logic      [scif_pkg::IRQ_N-1:0]   irq_identification_reg_o,
  output logic                              combined_irq_o
);
  localparam int TW = scif_pkg::TIME_W;
  typedef struct packed {
    scif_pkg::scif_sess_t       sess;
    scif_pkg::scif_link_t       link;
    logic [TW-1:0]              sess_cnt;
    logic [TW-1:0]              space_cnt;
    logic [TW-1:0]              idle_cnt;
    logic [TW-1:0]              baud_cnt;
    logic [scif_pkg::DIV_W-1:0] adj_cnt;
    logic [scif_pkg::DIV_W-1:0] div_cnt;
    logic                       clk_en;
    logic [3:0]                 bit_idx;
    logic [scif_pkg::FRAME_W-1:0] shreg;
    logic [scif_pkg::RTRY_W-1:0]  retry;
    logic                       perr;
    logic                       last_tx;
    logic                       tx_err;
    logic [2:0]                 io_sync;
    logic [1:0]                 det_sync;
    scif_pkg::scif_card_t       card;
    logic [scif_pkg::IRQ_N-1:0] irq;
    logic                       comb_irq;
    logic [scif_pkg::RXE_W-1:0] rx_rdata;
    logic                       rx_rvalid;
  } scif_st_t;
  scif_st_t                    st;
  scif_st_t                    next_st;
  logic [scif_pkg::DATA_W-1:0] tx_rdata;
  logic [scif_pkg::RXE_W-1:0]  rx_head;
  logic [scif_pkg::RXE_W-1:0]  rx_wdata;
  logic                        tx_pop;
  logic                        rx_push;
  logic                        baud_wrap;
  logic                        etu_tick;
  logic                        mid_tick;
  logic                        div_wrap;
  logic                        cclk_rise;
  logic                        sess_tick;
  logic                        sess_done;
  logic                        io;
  logic                        det;
  logic                        io_fall;
  logic                        active;
  logic                        rx_ok;
  logic [TW-1:0]               guard;
  logic [scif_pkg::IRQ_N-1:0]  ev;
  // ==========================================================
  // Buffers
  scif_fifo #(.W(scif_pkg::DATA_W), .DEPTH(scif_pkg::DEPTH),
              .CW(scif_pkg::CNT_W)) u_txf (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .wr_i    (tx_wr_i),
    .wdata_i (tx_wdata_i),
    .rd_i    (tx_pop),
    .flush_i (tx_flush_i),
    .rdata_o (tx_rdata),
    .count_o (tx_count_o)
  );
  scif_fifo #(.W(scif_pkg::RXE_W), .DEPTH(scif_pkg::DEPTH),
              .CW(scif_pkg::CNT_W)) u_rxf (
    .mclk_i  (mclk_i),
    .rstn_i  (rstn_i),
    .wr_i    (rx_push),
    .wdata_i (rx_wdata),
    .rd_i    (rx_rd_i),
    .flush_i (1'b0),
    .rdata_o (rx_head),
    .count_o (rx_count_o)
  );
  // ==========================================================
  // Next state
  always_comb begin
    next_st   = st;
    ev        = '0;
    tx_pop    = 1'b0;
    rx_push   = 1'b0;
    rx_wdata  = '0;
    io        = st.io_sync[1];
    det       = st.det_sync[1];
    io_fall   = st.io_sync[2] && !st.io_sync[1];
    // Pins cross in through two flops; bit 2 only feeds edge detect
    next_st.io_sync  = {st.io_sync[1:0], card_io_i};
    next_st.det_sync = {st.det_sync[0], card_detect_i};
    // Etu timing from two cascaded counters
    baud_wrap = st.baud_cnt == cfg_i.baud;
    etu_tick  = baud_wrap && st.adj_cnt == cfg_i.adjust;
    mid_tick  = baud_wrap && st.adj_cnt == (cfg_i.adjust >> 1);
    next_st.baud_cnt = baud_wrap ? '0 : st.baud_cnt + 1'b1;
    if (baud_wrap) begin
      next_st.adj_cnt = etu_tick ? '0 : st.adj_cnt + 1'b1;
    end
    // Card clock divider; clock parks low when disabled
    div_wrap  = st.div_cnt == cfg_i.clkdiv;
    cclk_rise = div_wrap && st.clk_en && !st.card.clk;
    next_st.div_cnt = div_wrap ? '0 : st.div_cnt + 1'b1;
    if (!st.clk_en) begin
      next_st.card.clk = 1'b0;
    end else if (div_wrap) begin
      next_st.card.clk = !st.card.clk;
    end
    // Spacing and idle counters saturate instead of wrapping
    if (etu_tick && ~&st.space_cnt) begin
      next_st.space_cnt = st.space_cnt + 1'b1;
    end
    if (rx_rd_i || rx_count_o == '0) begin
      next_st.idle_cnt = '0;
    end else if (etu_tick && ~&st.idle_cnt) begin
      next_st.idle_cnt = st.idle_cnt + 1'b1;
    end
    // ========================================================
    // Session sequencing on one shared down counter
    case (st.sess)
      scif_pkg::S_ATR_WAIT: sess_tick = cclk_rise;
      scif_pkg::S_ATR_RX:   sess_tick = etu_tick;
      default:              sess_tick = 1'b1;
    endcase
    sess_done = sess_tick && st.sess_cnt == '0;
    if (sess_tick && st.sess_cnt != '0) begin
      next_st.sess_cnt = st.sess_cnt - 1'b1;
    end
    active = st.sess >= scif_pkg::S_PWR && st.sess <= scif_pkg::S_WARM;
    rx_ok  = st.sess == scif_pkg::S_ATR_WAIT ||
             st.sess == scif_pkg::S_ATR_RX || st.sess == scif_pkg::S_SESSION;
    if (active && (!det || deact_req_i)) begin
      ev[scif_pkg::IRQ_CARD_OUT] = !det;
      next_st.sess     = scif_pkg::S_DEACT_RST;
      next_st.sess_cnt = cfg_i.deact_time;
    end else begin
      case (st.sess)
        scif_pkg::S_NOCARD: begin
          if (det) begin
            next_st.sess     = scif_pkg::S_DEBOUNCE;
            next_st.sess_cnt = cfg_i.stable_time;
          end
        end
        scif_pkg::S_DEBOUNCE: begin
          if (!det) begin
            next_st.sess = scif_pkg::S_NOCARD;
          end else if (sess_done) begin
            next_st.sess = scif_pkg::S_READY;
            ev[scif_pkg::IRQ_CARD_IN] = 1'b1;
          end
        end
        scif_pkg::S_READY: begin
          if (!det) begin
            next_st.sess = scif_pkg::S_NOCARD;
            ev[scif_pkg::IRQ_CARD_OUT] = 1'b1;
          end else if (start_act_i) begin
            next_st.sess     = scif_pkg::S_PWR;
            next_st.card.pwr = 1'b1;
            next_st.sess_cnt = cfg_i.act_time;
          end
        end
        scif_pkg::S_PWR: begin
          if (sess_done) begin
            next_st.sess     = scif_pkg::S_CLK;
            next_st.clk_en   = 1'b1;
            next_st.sess_cnt = cfg_i.act_time;
          end
        end
        scif_pkg::S_CLK, scif_pkg::S_WARM: begin
          if (sess_done) begin
            next_st.sess       = scif_pkg::S_ATR_WAIT;
            next_st.card.rst_n = 1'b1;
            next_st.sess_cnt   = cfg_i.atr_start_time;
            ev[scif_pkg::IRQ_CARD_UP] = st.sess == scif_pkg::S_CLK;
          end
        end
        scif_pkg::S_ATR_WAIT: begin
          if (st.link == scif_pkg::L_RX) begin
            next_st.sess     = scif_pkg::S_ATR_RX;
            next_st.sess_cnt = cfg_i.atr_dur_time;
          end else if (sess_done) begin
            ev[scif_pkg::IRQ_ATR_STO] = 1'b1;
            next_st.sess     = scif_pkg::S_DEACT_RST;
            next_st.sess_cnt = cfg_i.deact_time;
          end
        end
        scif_pkg::S_ATR_RX: begin
          if (atr_done_i) begin
            next_st.sess = scif_pkg::S_SESSION;
          end else if (sess_done) begin
            ev[scif_pkg::IRQ_ATR_DTO] = 1'b1;
            next_st.sess     = scif_pkg::S_DEACT_RST;
            next_st.sess_cnt = cfg_i.deact_time;
          end
        end
        scif_pkg::S_SESSION: begin
          if (warm_rst_i) begin
            next_st.sess       = scif_pkg::S_WARM;
            next_st.card.rst_n = 1'b0;
            next_st.sess_cnt   = cfg_i.act_time;
          end
        end
        scif_pkg::S_DEACT_RST: begin
          next_st.card.rst_n = 1'b0;
          if (sess_done) begin
            next_st.sess     = scif_pkg::S_DEACT_CLK;
            next_st.clk_en   = 1'b0;
            next_st.sess_cnt = cfg_i.deact_time;
          end
        end
        scif_pkg::S_DEACT_CLK: begin
          if (sess_done) begin
            next_st.sess         = scif_pkg::S_DEACT_PWR;
            next_st.card.io_out  = 1'b0;
            next_st.card.io_oe_n = 1'b0;
            next_st.sess_cnt     = cfg_i.deact_time;
          end
        end
        scif_pkg::S_DEACT_PWR: begin
          if (sess_done) begin
            next_st.sess         = det ? scif_pkg::S_READY
                                       : scif_pkg::S_NOCARD;
            next_st.card.pwr     = 1'b0;
            next_st.card.io_oe_n = 1'b1;
            ev[scif_pkg::IRQ_CARD_DN] = 1'b1;
          end
        end
        default: next_st.sess = scif_pkg::S_NOCARD;
      endcase
    end
    // ========================================================
    // Character link; the engine abandons a frame on deactivation
    guard = st.last_tx ? cfg_i.char_guard : cfg_i.block_guard;
    case (st.link)
      scif_pkg::L_IDLE: begin
        if (rx_ok && io_fall) begin
          next_st.link      = scif_pkg::L_RX;
          next_st.bit_idx   = '0;
          next_st.baud_cnt  = '0;
          next_st.adj_cnt   = '0;
          next_st.space_cnt = '0;
          next_st.last_tx   = 1'b0;
        end else if (st.sess == scif_pkg::S_SESSION && tx_mode_i &&
                     tx_count_o != '0 && !st.tx_err &&
                     st.space_cnt >= guard) begin
          next_st.link         = scif_pkg::L_TX;
          next_st.bit_idx      = '0;
          next_st.baud_cnt     = '0;
          next_st.adj_cnt      = '0;
          next_st.space_cnt    = '0;
          next_st.last_tx      = 1'b1;
          next_st.shreg        = {^tx_rdata, tx_rdata, 1'b0};
          next_st.card.io_out  = 1'b0;
          next_st.card.io_oe_n = 1'b0;
        end
        if (rx_ok && etu_tick) begin
          ev[scif_pkg::IRQ_CHAR_TO] = !st.last_tx &&
                                      st.space_cnt == cfg_i.char_timeout;
          ev[scif_pkg::IRQ_BLK_TO]  = st.last_tx &&
                                      st.space_cnt == cfg_i.block_timeout;
        end
      end
      scif_pkg::L_TX: begin
        if (etu_tick) begin
          next_st.bit_idx = st.bit_idx + 1'b1;
          next_st.shreg   = st.shreg >> 1;
          next_st.card.io_out  = st.shreg[1];
          next_st.card.io_oe_n = st.bit_idx >= scif_pkg::FRM_PAR;
        end
        if (mid_tick && st.bit_idx == scif_pkg::FRM_ERR) begin
          next_st.link = scif_pkg::L_IDLE;
          if (!io && !cfg_i.t1_mode) begin
            // Character stays at the head for the retry
            if (st.retry == cfg_i.tx_retry) begin
              next_st.tx_err = 1'b1;
              next_st.retry  = '0;
            end else begin
              next_st.retry = st.retry + 1'b1;
            end
          end else begin
            tx_pop        = 1'b1;
            next_st.retry = '0;
          end
        end
      end
      scif_pkg::L_RX: begin
        if (mid_tick) begin
          next_st.bit_idx = st.bit_idx + 1'b1;
          if (st.bit_idx == '0) begin
            // A glitch shorter than half a bit is not a start bit
            if (io) begin
              next_st.link = scif_pkg::L_IDLE;
            end
          end else if (st.bit_idx < scif_pkg::FRM_PAR) begin
            next_st.shreg = {io, st.shreg[scif_pkg::FRAME_W-1:1]};
          end else if (st.bit_idx == scif_pkg::FRM_PAR) begin
            next_st.perr = ^{st.shreg[scif_pkg::FRAME_W-1:2], io};
            rx_push  = 1'b1;
            rx_wdata = {next_st.perr,
                        st.shreg[scif_pkg::FRAME_W-1:2]};
            if (!next_st.perr || cfg_i.t1_mode) begin
              next_st.link = scif_pkg::L_IDLE;
            end
          end else if (st.bit_idx == scif_pkg::FRM_ERR) begin
            next_st.card.io_out  = 1'b0;
            next_st.card.io_oe_n = 1'b0;
          end else begin
            next_st.card.io_oe_n = 1'b1;
            next_st.link         = scif_pkg::L_IDLE;
          end
        end
      end
      default: next_st.link = scif_pkg::L_IDLE;
    endcase
    if (!rx_ok && !active) begin
      next_st.link = scif_pkg::L_IDLE;
    end
    if (tx_flush_i && !next_st.tx_err) begin
      next_st.tx_err = 1'b0;
    end else if (tx_flush_i && !(st.link == scif_pkg::L_TX && mid_tick &&
                 st.bit_idx == scif_pkg::FRM_ERR)) begin
      next_st.tx_err = 1'b0;
    end
    // ========================================================
    // Host read port and interrupt lines
    next_st.rx_rvalid = rx_rd_i && rx_count_o != '0;
    if (next_st.rx_rvalid) begin
      next_st.rx_rdata = rx_head;
    end
    // Set wins over a clear landing in the same cycle
    next_st.irq = ((st.irq & ~irq_clear_i) | ev) & scif_pkg::IRQ_STICKY;
    next_st.irq[scif_pkg::IRQ_TX_ERR]  = next_st.tx_err;
    next_st.irq[scif_pkg::IRQ_RX_TOUT] = rx_count_o != '0 &&
        st.idle_cnt >= cfg_i.rx_idle_time_setting;
    next_st.irq[scif_pkg::IRQ_TX_LVL]  = tx_count_o < cfg_i.tx_tide;
    next_st.irq[scif_pkg::IRQ_RX_LVL]  = rx_count_o > cfg_i.rx_tide;
    next_st.comb_irq = |next_st.irq;
  end
  // ==========================================================
  // State register
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st              <= '0;
      st.io_sync      <= '1;
      st.card.io_oe_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end
  assign card_pwr_o               = st.card.pwr;
  assign card_clock_out_o         = st.card.clk;
  assign card_rst_n_o             = st.card.rst_n;
  assign card_io_o                = st.card.io_out;
  assign card_io_oe_n_o           = st.card.io_oe_n;
  assign rx_rdata_o               = st.rx_rdata;
  assign rx_rvalid_o              = st.rx_rvalid;
  assign irq_identification_reg_o = st.irq;
  assign combined_irq_o           = st.comb_irq;
endmodule

// ### verification/scif_core_properties.sv
// Port checker for the smart card interface core
`timescale 1ns/1ps
module scif_core_checker (
  input wire logic                       mclk_i,
  input wire logic                       rstn_i,
  input wire scif_pkg::scif_cfg_t        cfg_i,
  input wire logic                       tx_wr_i,
  input wire logic                       tx_flush_i,
  input wire logic                       rx_rd_i,
  input wire logic                       card_pwr_o,
  input wire logic                       card_clock_out_o,
  input wire logic                       card_rst_n_o,
  input wire logic                       rx_rvalid_o,
  input wire logic [scif_pkg::CNT_W-1:0] tx_count_o,
  input wire logic [scif_pkg::CNT_W-1:0] rx_count_o,
  input wire logic [scif_pkg::IRQ_N-1:0] irq_identification_reg_o,
  input wire logic                       combined_irq_o
);
  wire [11:0] irq = irq_identification_reg_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================================================
  // Assertions and cover points
  a_combined_or: assert property (combined_irq_o == |irq)
    else $error("combined line differs from OR");
  // Level lines are registered, so they follow the fill one cycle late
  a_tx_level: assert property ($past(rstn_i) |->
    irq[10] == $past(tx_count_o < cfg_i.tx_tide))
    else $error("tx level line wrong");
  a_rx_level: assert property ($past(rstn_i) |->
    irq[11] == $past(rx_count_o > cfg_i.rx_tide))
    else $error("rx level line wrong");
  a_fill_bound: assert property (
    tx_count_o <= 4'h8 && rx_count_o <= 4'h8)
    else $error("fill above eight");
  a_read_answer: assert property (
    rx_rd_i && rx_count_o != 0 |=> rx_rvalid_o)
    else $error("read got no valid");
  a_valid_cause: assert property (rx_rvalid_o |->
    $past(rx_rd_i) && $past(rx_count_o) != 0)
    else $error("valid without read");
  a_flush_clears: assert property (
    tx_flush_i && !tx_wr_i |=> tx_count_o == 0)
    else $error("flush left entries");
  a_error_holds: assert property (irq[4] && !tx_flush_i |=> irq[4])
    else $error("tx error dropped unflushed");
  a_tout_cause: assert property (irq[9] |->
    rx_count_o != 0 || $past(rx_rd_i))
    else $error("rx timeout with empty buffer");
  a_power_first: assert property (
    card_rst_n_o || card_clock_out_o |-> card_pwr_o)
    else $error("card reset or clock without power");
  c_full_write: cover property (tx_count_o == 4'h8 && tx_wr_i);
  c_rx_tout: cover property (irq[9]);
  c_deact_done: cover property (irq[3]);
endmodule
bind scif_core scif_core_checker u_chk (.*);

// ### verification/scif_card_model.sv
// Behavioural card that sends framed characters on the data line
`timescale 1ns/1ps
module scif_card_model #(
  parameter int ETU = 4
) (
  input  wire logic mclk_i,
  output logic      io_o
);
  // Released line reads high through the pull-up
  initial io_o = 1'b1;
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {(^d) ^ bad, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i) io_o <= f[i];
      repeat (ETU - 1) @(posedge mclk_i);
    end
    @(posedge mclk_i) io_o <= 1'b1;
    repeat (3 * ETU) @(posedge mclk_i);
  endtask
  task automatic hold(input logic v);
    @(posedge mclk_i) io_o <= v;
  endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the smart card interface core
`timescale 1ns/1ps
module tb;
  logic                mclk_i = 1'b0;
  logic                rstn_i = 1'b0;
  scif_pkg::scif_cfg_t cfg = '0;
  logic                det = 1'b0, act = 1'b0, deact = 1'b0, wr = 1'b0;
  logic                fl = 1'b0, rd = 1'b0, cio, pwr, cclk, crst_n;
  logic                atr = 1'b0, txm = 1'b0, cio_card;
  logic                io_o, io_oe_n, rvalid, cirq;
  logic [7:0]          wdata = 8'h00;
  logic [11:0]         clr = 12'h000, irq;
  logic [8:0]          rdata;
  logic [3:0]          txc, rxc;
  int                  bad_count = 0, checked = 0, n;
  always #25 mclk_i = ~mclk_i;
  // Data line: card pulls low, core drives only while enabled low
  assign cio = cio_card & (io_oe_n | io_o);
  scif_card_model card (.mclk_i(mclk_i), .io_o(cio_card));
  scif_core dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .cfg_i(cfg),
    .card_detect_i(det), .start_act_i(act), .deact_req_i(deact),
    .warm_rst_i(1'b0), .atr_done_i(atr), .tx_mode_i(txm), .tx_wr_i(wr),
    .tx_wdata_i(wdata), .tx_flush_i(fl), .rx_rd_i(rd), .irq_clear_i(clr),
    .card_io_i(cio), .card_pwr_o(pwr), .card_clock_out_o(cclk),
    .card_rst_n_o(crst_n), .card_io_o(io_o), .card_io_oe_n_o(io_oe_n),
    .rx_rdata_o(rdata), .rx_rvalid_o(rvalid), .tx_count_o(txc),
    .rx_count_o(rxc), .irq_identification_reg_o(irq),
    .combined_irq_o(cirq));
  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_tx_fill();
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk_i) wr <= 1'b1;
      wdata <= 8'h10 + 8'(i);
    end
    @(posedge mclk_i) wr <= 1'b0;
    @(negedge mclk_i);
    chk(16'(txc), 16'h0008);
    chk(16'(irq[10]), 16'h0000);
    @(posedge mclk_i) fl <= 1'b1;
    @(posedge mclk_i) fl <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(16'(txc), 16'h0000);
    chk(16'(irq[10]), 16'h0001);
    $display("test tx fill done");
  endtask
  task automatic test_activate();
    @(posedge mclk_i) det <= 1'b1;
    for (n = 0; n < 300 && irq[0] !== 1'b1; n++) @(negedge mclk_i);
    chk(16'(irq[0]), 16'h0001);
    @(posedge mclk_i) clr <= 12'h001;
    act <= 1'b1;
    @(posedge mclk_i) clr <= 12'h000;
    act <= 1'b0;
    for (n = 0; n < 500 && crst_n !== 1'b1; n++) @(negedge mclk_i);
    chk(16'({pwr, crst_n}), 16'h0003);
    $display("test activate done");
  endtask
  task automatic test_rx();
    card.send(8'ha5, 1'b0);
    card.send(8'h3c, 1'b1);
    @(negedge mclk_i);
    chk(16'(rxc), 16'h0002);
    chk(16'({cirq, irq[11]}), 16'h0003);
    repeat (40) @(negedge mclk_i);
    chk(16'(irq[9]), 16'h0001);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i) rd <= 1'b1;
      @(posedge mclk_i) rd <= 1'b0;
      @(negedge mclk_i);
      chk(16'({rvalid, rdata}), i ? 16'h033c : 16'h02a5);
    end
    repeat (2) @(negedge mclk_i);
    chk(16'({irq[9], rxc}), 16'h0000);
    $display("test rx done");
  endtask
  task automatic test_tx_err();
    @(posedge mclk_i) atr <= 1'b1;
    @(posedge mclk_i) txm <= 1'b1;
    wr <= 1'b1;
    @(posedge mclk_i) wr <= 1'b0;
    card.hold(1'b0);
    for (n = 0; n < 100 && irq[4] !== 1'b1; n++) @(negedge mclk_i);
    card.hold(1'b1);
    repeat (60) @(negedge mclk_i);
    chk(16'({irq[4], txc, io_oe_n}), 16'h0023);
    @(posedge mclk_i) fl <= 1'b1;
    @(posedge mclk_i) fl <= 1'b0;
    repeat (2) @(negedge mclk_i);
    chk(16'({irq[4], txc}), 16'h0000);
    $display("test tx error done");
  endtask
  task automatic test_deact();
    @(posedge mclk_i) deact <= 1'b1;
    for (n = 0; n < 300 && irq[3] !== 1'b1; n++) @(negedge mclk_i);
    chk(16'({irq[3], pwr, crst_n, cclk}), 16'h0008);
    @(posedge mclk_i) deact <= 1'b0;
    $display("test deactivate done");
  endtask
  initial begin
    cfg.baud = 16'h0001;
    cfg.adjust = 8'h01;
    cfg.clkdiv = 8'h01;
    cfg.stable_time = 16'h000a;
    cfg.act_time = 16'h0014;
    cfg.atr_start_time = 16'hffff;
    cfg.atr_dur_time = 16'hffff;
    cfg.deact_time = 16'h0005;
    cfg.rx_idle_time_setting = 16'h0004;
    cfg.char_timeout = 16'hffff;
    cfg.block_timeout = 16'hffff;
    cfg.tx_tide = 4'h4;
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    test_tx_fill();
    test_activate();
    test_rx();
    test_tx_err();
    test_deact();
    close_out();
  end
  // Whole run takes a few hundred cycles; this cuts a hang short
  initial begin
    #500000;
    bad_count++;
    close_out();
  end
endmodule
